// ---- inc/clock_monitor_params.svh ----
// constants for the clock monitor reference generator
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses
`ifndef CLOCK_MONITOR_PARAMS_SVH
`define CLOCK_MONITOR_PARAMS_SVH

// ****************************************************************
// register map (byte addresses)
// ****************************************************************
`define OFS_CTRL         4'h0
`define OFS_STATUS       4'h4
`define OFS_IRQ_STATUS   4'h8
`define OFS_IRQ_MASK     4'hC
`define ADDR_W           4

// ****************************************************************
// field positions
// ****************************************************************
`define CTRL_W           5
`define CTRL_RESET       5'h00
`define STAT_STABLE      0
`define STAT_EXT_REF     1
`define STAT_INT_REF     2
`define STAT_STAB_CLK    3
`define STAT_EXT_ON      4
`define IRQ_W            2
`define IRQ_STABLE_SET   0
`define IRQ_STABLE_LOST  1

// ****************************************************************
// divider taps: output bit of a counter stepped once per source edge
// ****************************************************************
`define LONG_W           14
`define SHORT_W          2
`define TAP_DIV4         1
`define TAP_EXT_REF      8
`define TAP_INT_XTAL     5
`define TAP_INT_SLOW     13
`define TAP_STAB_SHORT   3
`define TAP_STAB_LONG    11

`endif

// ---- inc/clock_monitor_pkg.sv ----
// types shared by the clock monitor reference generator
// assumes clock_monitor_params.svh supplies the widths
`include "clock_monitor_params.svh"

package clock_monitor_pkg;

   // software configuration bits, high bit first on the bus
   typedef struct packed {
      logic monitorEnable;
      logic crystalEnable;
      logic slowExternalSel;
      logic intGenOn;
      logic extGenEnable;
   } ctrl_type;

   // long divider source and role
   typedef enum logic [2:0] {
      LONG_STAB = 3'b001,
      LONG_EXT  = 3'b010,
      LONG_BASE = 3'b100
   } long_mode_type;

   typedef struct packed {
      logic extReference;
      logic intReference;
      logic stabilizationClock;
   } refs_type;

endpackage : clock_monitor_pkg

// ---- src/clock_monitor_reference_gen.sv ----
// clock monitor reference generator with wishbone register access
// assumes ext pin and base clock are asynchronous to ref_clk and much
// slower than it; ext_inactive_flag comes from logic on ref_clk
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`include "clock_monitor_params.svh"

module clock_monitor_reference_gen
   import clock_monitor_pkg::*;
(
   input  wire logic        ref_clk,          // system clock, 125 MHz
   input  wire logic        rst,              // synchronous reset, active high
   input  wire logic [31:0] wb_adr_i,         // wishbone byte address
   input  wire logic [31:0] wb_dat_i,         // wishbone write data
   input  wire logic [3:0]  wb_sel_i,         // wishbone byte enables
   input  wire logic        wb_we_i,          // wishbone write
   input  wire logic        wb_cyc_i,         // wishbone cycle
   input  wire logic        wb_stb_i,         // wishbone strobe
   output logic      [31:0] wb_dat_o,         // wishbone read data
   output logic             wb_ack_o,         // wishbone acknowledge
   input  wire logic        extClockInputPin, // external clock or port pin
   input  wire logic        intBaseClock,     // internal base clock, ~307.2 kHz
   input  wire logic        extInactiveFlag,  // ext clock inactivity from detector
   output logic             extClock,         // buffered external clock
   output logic             portPinIn,        // pin level for port use
   output logic             extReference,     // reference for internal checking
   output logic             intReference,     // reference for external checking
   output logic             stabilizationClock, // stabilization timer clock
   output logic             extClockStable,   // external clock stable flag
   output logic             monitorEnable,    // monitor enable to detectors
   output logic             irq               // level interrupt
);

   // ****************************************************************
   // functions
   // ****************************************************************
   // stabilization tap: crystal needs the long count
   function automatic logic stabTap(input logic [`LONG_W-1:0] cnt, input logic xtal);
      stabTap = xtal ? cnt[`TAP_STAB_LONG] : cnt[`TAP_STAB_SHORT];
   endfunction : stabTap

   function automatic logic [31:0] pad(input logic [7:0] v);
      pad = {24'h00_0000, v};
   endfunction : pad

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   logic [2:0] extSync_r;
   logic [2:0] baseSync_r;

   always_ff @(posedge ref_clk) begin
      if (rst)
         extSync_r <= 3'h0;
      else
         extSync_r <= {extSync_r[1:0], extClockInputPin};
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         baseSync_r <= 3'h0;
      else
         baseSync_r <= {baseSync_r[1:0], intBaseClock};
   end

   ctrl_type ctrl_r;
   logic     extRise;
   logic     baseRise;

   // edges seen from the second flop onward only
   assign extRise  = extSync_r[1] & ~extSync_r[2] & ctrl_r.extGenEnable;
   assign baseRise = baseSync_r[1] & ~baseSync_r[2] & ctrl_r.intGenOn;

   always_ff @(posedge ref_clk) begin
      if (rst)
         extClock <= 1'b0;
      else
         extClock <= ctrl_r.extGenEnable & extSync_r[1];
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         portPinIn <= 1'b0;
      else
         portPinIn <= ~ctrl_r.extGenEnable & extSync_r[1];
   end

   // ****************************************************************
   // divider selection
   // ****************************************************************
   logic                stable_r;
   long_mode_type       longMode;
   logic [4:0]          selKey;
   logic [4:0]          selKey_r;
   logic                selChange;
   logic                selChange_r;
   logic                longStep;

   always_comb begin
      if (!stable_r)
         longMode = LONG_STAB;
      else if (ctrl_r.slowExternalSel)
         longMode = LONG_BASE;
      else
         longMode = LONG_EXT;
   end

   always_comb begin
      case (longMode)
         LONG_BASE: longStep = baseRise;
         LONG_EXT:  longStep = extRise;
         LONG_STAB: longStep = extRise;
         default:   longStep = 1'b0;
      endcase
   end

   assign selKey    = {longMode, ctrl_r.crystalEnable, ctrl_r.intGenOn};
   assign selChange = selKey != selKey_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         selKey_r    <= 5'h00;
         selChange_r <= 1'b0;
      end else begin
         selKey_r    <= selKey;
         selChange_r <= selChange;
      end
   end

   // ****************************************************************
   // dividers, each stepped by its own source edge
   // ****************************************************************
   logic [`LONG_W-1:0]  longCnt_r;
   logic [`SHORT_W-1:0] extDiv4_r;
   logic [`SHORT_W-1:0] baseDiv4_r;

   always_ff @(posedge ref_clk) begin
      if (rst || !ctrl_r.extGenEnable)
         longCnt_r <= '0;
      else if (selChange)
         longCnt_r <= '0;
      else if (longStep)
         longCnt_r <= longCnt_r + 1'b1;
   end

   always_ff @(posedge ref_clk) begin
      if (rst || !ctrl_r.extGenEnable || selChange)
         extDiv4_r <= '0;
      else if (extRise)
         extDiv4_r <= extDiv4_r + 1'b1;
   end

   always_ff @(posedge ref_clk) begin
      if (rst || !ctrl_r.intGenOn || selChange)
         baseDiv4_r <= '0;
      else if (baseRise)
         baseDiv4_r <= baseDiv4_r + 1'b1;
   end

   // ****************************************************************
   // reference selection
   // ****************************************************************
   refs_type refsNxt;

   always_comb begin
      refsNxt = '0;
      // ext reference: never during stabilization
      if (ctrl_r.extGenEnable && stable_r) begin
         if (ctrl_r.slowExternalSel)
            refsNxt.extReference = extDiv4_r[`TAP_DIV4];
         else
            refsNxt.extReference = longCnt_r[`TAP_EXT_REF];
      end
      // int reference off with its generator
      if (ctrl_r.intGenOn) begin
         if (ctrl_r.slowExternalSel && stable_r) begin
            if (ctrl_r.crystalEnable)
               refsNxt.intReference = longCnt_r[`TAP_INT_XTAL];
            else
               refsNxt.intReference = longCnt_r[`TAP_INT_SLOW];
         end else begin
            refsNxt.intReference = baseDiv4_r[`TAP_DIV4];
         end
      end
      if (ctrl_r.extGenEnable)
         refsNxt.stabilizationClock = stabTap(longCnt_r, ctrl_r.crystalEnable);
   end

   // references run whenever their sources do, but the ext reference stays low
   // until the stable flag is set, so the detectors see that direction only after stabilization
   always_ff @(posedge ref_clk) begin
      if (rst)
         extReference <= 1'b0;
      else
         extReference <= refsNxt.extReference;
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         intReference <= 1'b0;
      else
         intReference <= refsNxt.intReference;
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         stabilizationClock <= 1'b0;
      else
         stabilizationClock <= refsNxt.stabilizationClock;
   end

   // ****************************************************************
   // stable flag
   // ****************************************************************
   logic stabFall;
   logic stableSetEv;
   logic stableLostEv;

   // the output flop still holds the pre-restart tap for one cycle after
   // a selection change, so that cycle is masked too: no false set
   assign stabFall = stabilizationClock & ~refsNxt.stabilizationClock & ~selChange &
                     ~selChange_r;
   assign stableSetEv  = stabFall & ~stable_r & ctrl_r.extGenEnable;
   assign stableLostEv = stable_r & extInactiveFlag & ctrl_r.extGenEnable;

   // clearing wins: an off generator or a dead clock cannot be stable
   always_ff @(posedge ref_clk) begin
      if (rst)
         stable_r <= 1'b0;
      else if (!ctrl_r.extGenEnable || extInactiveFlag)
         stable_r <= 1'b0;
      else if (stabFall)
         stable_r <= 1'b1;
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         extClockStable <= 1'b0;
      else
         extClockStable <= stable_r & ~extInactiveFlag & ctrl_r.extGenEnable;
   end

   // ****************************************************************
   // interrupts
   // ****************************************************************
   logic [`IRQ_W-1:0] irqStatus_r;
   logic [`IRQ_W-1:0] irqMask_r;
   logic [`IRQ_W-1:0] irqEvents;
   logic [`IRQ_W-1:0] irqClear;
   logic              busWrite;
   logic              busAccess;
   logic [`ADDR_W-1:0] addr;

   assign addr      = wb_adr_i[`ADDR_W-1:0];
   assign busAccess = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   // writes land at the edge where the master samples ack high
   assign busWrite  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0] &
                      (wb_adr_i[31:`ADDR_W] == '0);

   assign irqEvents = {stableLostEv, stableSetEv};
   assign irqClear  = (busWrite && addr == `OFS_IRQ_STATUS) ?
                      wb_dat_i[`IRQ_W-1:0] : '0;

   // set wins over a clear in the same cycle
   always_ff @(posedge ref_clk) begin
      if (rst)
         irqStatus_r <= '0;
      else
         irqStatus_r <= (irqStatus_r & ~irqClear) | irqEvents;
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(irqStatus_r & irqMask_r);
   end

   // ****************************************************************
   // wishbone slave, one wait state, unmapped reads return zero
   // ****************************************************************
   logic [7:0] statusByte;

   assign statusByte = {3'h0, ctrl_r.extGenEnable, stabilizationClock,
                        intReference, extReference, extClockStable};

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_r    <= `CTRL_RESET;
         irqMask_r <= '0;
      end else if (busWrite) begin
         case (addr)
            `OFS_CTRL:     ctrl_r    <= wb_dat_i[`CTRL_W-1:0];
            `OFS_IRQ_MASK: irqMask_r <= wb_dat_i[`IRQ_W-1:0];
            default:       ;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst)
         monitorEnable <= 1'b0;
      else
         monitorEnable <= ctrl_r.monitorEnable;
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= busAccess;
         wb_dat_o <= 32'h0000_0000;
         if (busAccess && !wb_we_i && wb_adr_i[31:`ADDR_W] == '0) begin
            case (addr)
               `OFS_CTRL:       wb_dat_o <= pad({3'h0, ctrl_r});
               `OFS_STATUS:     wb_dat_o <= pad(statusByte);
               `OFS_IRQ_STATUS: wb_dat_o <= pad({6'h00, irqStatus_r});
               `OFS_IRQ_MASK:   wb_dat_o <= pad({6'h00, irqMask_r});
               default:         wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule : clock_monitor_reference_gen

// ---- tb/clock_monitor_props.sv ----
// port assertions for the clock monitor reference generator
// assumes one ref_clk domain and a synchronous active-high rst
`timescale 1ns/1ns

module clock_monitor_props (
   input wire logic        ref_clk,            // clock
   input wire logic        rst,                // reset
   input wire logic        wb_cyc_i,           // bus cycle
   input wire logic        wb_stb_i,           // bus strobe
   input wire logic [31:0] wb_dat_o,           // read data
   input wire logic        wb_ack_o,           // acknowledge
   input wire logic        extInactiveFlag,    // inactivity input
   input wire logic        extClock,           // buffered ext clock
   input wire logic        portPinIn,          // port use of pin
   input wire logic        extReference,       // ext reference
   input wire logic        stabilizationClock, // stabilization clock
   input wire logic        extClockStable      // stable flag
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_on_request: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked next cycle");
   a_no_stray_ack: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   a_pin_exclusive: assert property (!(extClock && portPinIn))
      else $error("pin routed both ways");
   a_inactive_clears: assert property (extInactiveFlag |=> !extClockStable)
      else $error("stable kept during inactivity");
   a_ref_quiet: assert property (!extClockStable [*3] |-> !extReference)
      else $error("ext reference during stabilization");
   a_stable_cause: assert property ($rose(extClockStable) |->
      $past(stabilizationClock, 2) || $past(stabilizationClock, 3))
      else $error("stable set without stabilization clock");
endmodule : clock_monitor_props

bind clock_monitor_reference_gen clock_monitor_props props (
   .ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .extInactiveFlag(extInactiveFlag),
   .extClock(extClock), .portPinIn(portPinIn), .extReference(extReference),
   .stabilizationClock(stabilizationClock), .extClockStable(extClockStable));

// ---- tb/clock_source_model.sv ----
// external clock source and internal base clock
// assumes the bench starts and stops the external source
`timescale 1ns/1ns

module clock_source_model #(
   parameter int HALF_EXT  = 24, // ext half period, ns
   parameter int HALF_BASE = 40  // base half period, ns; faster than nominal to keep runs short
) (
   input  wire logic runExt,  // ext source oscillating
   output logic      extPin,  // ext clock pin
   output logic      baseClk  // internal base clock
);
   initial extPin = 1'b0;
   initial baseClk = 1'b0;
   // a stopped source leaves the pin pulled low
   always #HALF_EXT extPin = runExt ? ~extPin : 1'b0;
   always #HALF_BASE baseClk = ~baseClk;
endmodule : clock_source_model

// ---- tb/tb.sv ----
// self-checking bench for the clock monitor reference generator
// assumes clock_source_model drives the pin and base clock
`timescale 1ns/1ns
`include "clock_monitor_params.svh"

module tb;
   logic        refClk, rst, we, cyc, stb, ack, runExt, inact, pin, base;
   logic [31:0] adr, datW, datR, rnd;
   logic [3:0]  sel;
   logic        extClk, portIn, extRef, intRef, stabClk, stable, monEn, irq;
   logic [31:0] expQ[$];
   int          n_fail, total_checks, cycles, extEdges, baseEdges, extRise, intRise, r;

   clock_source_model src (.runExt(runExt), .extPin(pin), .baseClk(base));
   clock_monitor_reference_gen dut (.ref_clk(refClk), .rst(rst), .wb_adr_i(adr),
      .wb_dat_i(datW), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_dat_o(datR), .wb_ack_o(ack), .extClockInputPin(pin), .intBaseClock(base),
      .extInactiveFlag(inact), .extClock(extClk), .portPinIn(portIn),
      .extReference(extRef), .intReference(intRef), .stabilizationClock(stabClk),
      .extClockStable(stable), .monitorEnable(monEn), .irq(irq));

   always #4 refClk = ~refClk;
   always @(posedge pin) extEdges++;
   always @(posedge base) baseEdges++;
   always @(posedge extRef) extRise++;
   always @(posedge intRef) intRise++;

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // ****************************************************************
   // bus master and read scoreboard
   // ****************************************************************
   task automatic wb(input logic hi, input logic [3:0] a, input logic w, input logic [31:0] d);
      @(posedge refClk);
      adr <= {27'h000_0000, hi, a};
      we <= w;
      datW <= d;
      cyc <= 1'b1;
      stb <= 1'b1;
      if (!w) expQ.push_back(d);
      do @(posedge refClk); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb

   always @(posedge refClk)
      if (ack === 1'b1 && we === 1'b0 && expQ.size() > 0) check(datR, expQ.pop_front());

   // counts reference rises over n source edges; s 1 picks the internal side
   task automatic measure(input bit s, input int n);
      int e0;
      r = s ? intRise : extRise;
      e0 = s ? baseEdges : extEdges;
      wait ((s ? baseEdges : extEdges) - e0 >= n);
      r = (s ? intRise : extRise) - r;
   endtask : measure

   // counting starts before the control write, so no pin edge is missed
   task automatic stab(input int n, input logic [31:0] c);
      int e0;
      e0 = extEdges;
      wb(1'b0, `OFS_CTRL, 1'b1, c);
      wait (stable === 1'b1);
      check(32'(extEdges - e0 >= n && extEdges - e0 <= n + 2), 1);
   endtask : stab

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   always @(posedge refClk) begin
      cycles++;
      if (cycles == 90000) begin
         n_fail++;
         wrap_up();
      end
   end

   initial begin
      {refClk, we, cyc, stb, inact, runExt} = 6'b00_0001;
      {adr, datW, sel, rst, rnd} = {64'h0000_0000_0000_0000, 4'hF, 1'b1, 32'h3384_8aa7};
      repeat (4) @(posedge refClk);
      rst <= 1'b0;
      for (int a = 0; a < 16; a += 4) wb(1'b0, 4'(a), 1'b0, 32'h0000_0000);
      rnd = xs(rnd);
      wb(1'b1, 4'h0, 1'b1, rnd);
      wb(1'b1, 4'h0, 1'b0, 32'h0000_0000);
      wb(1'b0, `OFS_IRQ_MASK, 1'b1, rnd);
      wb(1'b0, `OFS_IRQ_MASK, 1'b0, {30'h0, rnd[1:0]});
      wb(1'b0, `OFS_IRQ_MASK, 1'b1, 32'h0000_0003);
      stab(16, 32'h0000_0013);
      repeat (3) @(posedge refClk);
      check(irq, 1'b1);
      check({portIn, monEn}, 2'b01);
      wb(1'b0, `OFS_IRQ_STATUS, 1'b0, 32'h0000_0001);
      wb(1'b0, `OFS_IRQ_STATUS, 1'b1, 32'h0000_0001);
      wb(1'b0, `OFS_IRQ_STATUS, 1'b0, 32'h0000_0000);
      measure(1'b0, 2048);
      check(32'(r >= 3 && r <= 5), 1);
      measure(1'b1, 400);
      check(32'(r >= 99 && r <= 101), 1);
      wb(1'b0, `OFS_CTRL, 1'b1, 32'h0000_001F);
      measure(1'b0, 400);
      check(32'(r >= 99 && r <= 101), 1);
      measure(1'b1, 640);
      check(32'(r >= 9 && r <= 11), 1);
      @(posedge refClk);
      runExt <= 1'b0;
      inact <= 1'b1;
      @(posedge refClk);
      inact <= 1'b0;
      repeat (2) @(posedge refClk);
      check(stable, 1'b0);
      wb(1'b0, `OFS_IRQ_STATUS, 1'b0, 32'h0000_0002);
      runExt <= 1'b1;
      stab(4096, 32'h0000_000F);
      wb(1'b0, `OFS_CTRL, 1'b1, 32'h0000_001A);
      repeat (3) @(posedge refClk);
      check({stable, extClk}, 2'b00);
      measure(1'b0, 200);
      check(r, 0);
      wb(1'b0, `OFS_CTRL, 1'b1, 32'h0000_0000);
      measure(1'b1, 200);
      check(r, 0);
      wrap_up();
   end
endmodule : tb
